// File: rtl/captf_pkg.sv
// package: register map, field positions and types of the center-aligned pwm timer
`default_nettype none

package captf_pkg;

  localparam int NCH = 2;                        // channel count
  localparam int AW  = 8;                        // axi address width

  // byte addresses of the timer registers
  localparam logic [7:0] ADDR_SC    = 8'h00;     // timer_status_control
  localparam logic [7:0] ADDR_CNT   = 8'h04;     // counter (read), reset (write)
  localparam logic [7:0] ADDR_MODL  = 8'h08;     // modulus_low_byte
  localparam logic [7:0] ADDR_MODH  = 8'h0C;     // modulus_high_byte
  // channel n sits at CH_BASE + n * CH_STRIDE
  localparam logic [7:0] CH_BASE    = 8'h10;
  localparam logic [7:0] CH_STRIDE  = 8'h10;
  localparam logic [7:0] CH_OFS_SC  = 8'h00;     // channel_status_control
  localparam logic [7:0] CH_OFS_VL  = 8'h04;     // channel_value_low_byte
  localparam logic [7:0] CH_OFS_VH  = 8'h08;     // channel_value_high_byte

  // timer_status_control bit positions
  localparam int SC_FLAG  = 7;                   // overflow_flag
  localparam int SC_IE    = 6;                   // overflow_irq_enable
  localparam int SC_CENTER_ALIGN_SELECT = 5;                   // center_align_select
  localparam int SC_RUN   = 3;                   // counter runs when set

  // channel_status_control bit positions
  localparam int CSC_FLAG = 7;                   // channel_flag
  localparam int CSC_IE   = 6;                   // channel_irq_enable
  localparam int CSC_MSB  = 5;                   // channel_mode_select_high
  localparam int CSC_MSA  = 4;                   // channel_mode_select_low
  localparam int CSC_ELSB = 3;                   // edge_level_select_high
  localparam int CSC_ELSA = 2;                   // edge_level_select_low

  // reset values
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] MOD_RST = 16'h0000;
  localparam logic [15:0] CV_RST  = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // channel control fields as one carrier
  typedef struct packed {
    logic ie;
    logic ms_high;
    logic ms_low;
    logic els_high;
    logic els_low;
  } captf_chctl_t;

  localparam captf_chctl_t CHCTL_RST = '0;

  // effective channel mode, one-hot
  typedef enum logic [4:0] {
    MODE_OFF  = 5'b00001,
    MODE_IC   = 5'b00010,
    MODE_OC   = 5'b00100,
    MODE_EPWM = 5'b01000,
    MODE_CPWM = 5'b10000
  } captf_mode_t;

endpackage : captf_pkg

`default_nettype wire

// File: rtl/captf_flag.sv
// one event flag with the read-then-write-zero clear sequence
`timescale 1ns/1ps
`default_nettype none

module captf_flag (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic set_evt,
  input  wire logic rd_seen,
  input  wire logic wr_zero,
  output logic      flag
);

  logic armed;

  // a new event always wins and restarts the clear sequence
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag  <= 1'b0;
      armed <= 1'b0;
    end else if (set_evt) begin
      flag  <= 1'b1;
      armed <= 1'b0;
    end else if (wr_zero && armed) begin
      flag  <= 1'b0;
      armed <= 1'b0;
    end else if (rd_seen && flag) begin
      armed <= 1'b1;
    end
  end

endmodule : captf_flag

`default_nettype wire

// File: rtl/captf_timer.sv
// center-aligned pwm timer with buffered reloads, channel flags and axi4-lite registers
//
// The AXI4-Lite interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - center mode counts zero up to modulus and back down; period twice modulus.
// - channel value zero or bit 15 set gives zero duty in center mode.
// - positive channel value above nonzero modulus gives full duty in center mode.
// - low polarity bit clear: up match drives low, down match drives high.
// - byte writes fill holding buffers; load after both bytes and counter reversal.
// - waiting for reversal applies to pwm channels only, not output compare.
// - center pwm buffers update together with the modulus at the reversal from the modulus; edge pwm values load at count zero, one clock after the modulus.
// - writing timer status control discards pending modulus bytes.
// - writing channel status control discards that channel's pending value bytes.
// - enabled interrupt request is a level while its flag is one.
// - flag clears only after read while set, then write of zero.
// - event between read and zero write restarts sequence, flag stays set.
// - up-count mode sets overflow flag on wrap to zero from terminal count.
// - up/down mode sets overflow flag when counter reverses from modulus.
// - input capture edge select chooses rising, falling, either or none.
// - output compare sets channel flag each time counter equals channel value.
// - edge pwm sets channel flag on the match ending the active part.
// - center pwm sets channel flag on both matches of each period.
// - zero and terminal counts each last one clock in up/down counting.
module captf_timer (
  input  wire logic                            aclk,
  input  wire logic                            aresetn,
  input  wire logic [captf_pkg::AW-1:0]        s_axi_awaddr,
  input  wire logic                            s_axi_awvalid,
  output logic                                 s_axi_awready,
  input  wire logic [31:0]                     s_axi_wdata,
  input  wire logic [3:0]                      s_axi_wstrb,
  input  wire logic                            s_axi_wvalid,
  output logic                                 s_axi_wready,
  output logic [1:0]                           s_axi_bresp,
  output logic                                 s_axi_bvalid,
  input  wire logic                            s_axi_bready,
  input  wire logic [captf_pkg::AW-1:0]        s_axi_araddr,
  input  wire logic                            s_axi_arvalid,
  output logic                                 s_axi_arready,
  output logic [31:0]                          s_axi_rdata,
  output logic [1:0]                           s_axi_rresp,
  output logic                                 s_axi_rvalid,
  input  wire logic                            s_axi_rready,
  input  wire logic [captf_pkg::NCH-1:0]       chan_in,
  output logic      [captf_pkg::NCH-1:0]       chan_out,
  output logic      [captf_pkg::NCH-1:0]       chan_oe,
  output logic                                 overflow_irq,
  output logic      [captf_pkg::NCH-1:0]       channel_irq
);

  localparam int NCH = captf_pkg::NCH;

  // register decode: returns 0 timer regs, 1..NCH channel, or NCH+1 unmapped
  function automatic logic [2:0] dec_unit(input logic [7:0] a);
    logic [7:0] rel;
    rel = a - captf_pkg::CH_BASE;
    if (a[1:0] != 2'b00)
      dec_unit = 3'(NCH + 1);
    else if (a < captf_pkg::CH_BASE)
      dec_unit = 3'd0;
    else if (rel[7:4] < 4'(NCH) && rel[3:0] <= captf_pkg::CH_OFS_VH[3:0])
      dec_unit = 3'(rel[7:4]) + 3'd1;
    else
      dec_unit = 3'(NCH + 1);
  endfunction : dec_unit

  // offset within the unit
  function automatic logic [7:0] dec_ofs(input logic [7:0] a);
    dec_ofs = {4'h0, a[3:0]};
  endfunction : dec_ofs

  // effective mode of one channel from its control and the center select
  function automatic captf_pkg::captf_mode_t ch_mode(input captf_pkg::captf_chctl_t c,
                                                      input logic center_align_select);
    if (center_align_select)
      ch_mode = (c.els_high | c.els_low) ? captf_pkg::MODE_CPWM : captf_pkg::MODE_OFF;
    else if (c.ms_high)
      ch_mode = captf_pkg::MODE_EPWM;
    else if (c.ms_low)
      ch_mode = captf_pkg::MODE_OC;
    else
      ch_mode = captf_pkg::MODE_IC;
  endfunction : ch_mode

  // control and state
  logic                         ovf_ie;
  logic                         center_align_select;
  logic                         run;
  logic [15:0]                  cnt;
  logic                         dir_down;
  logic [15:0]                  mod_work;
  logic [15:0]                  mod_buf;
  logic                         mod_lo_done;
  logic                         mod_hi_done;
  logic                         ovf_flag;
  captf_pkg::captf_chctl_t      chctl    [NCH];
  logic [15:0]                  cv_work  [NCH];
  logic [15:0]                  cv_buf   [NCH];
  logic                         cv_lo_done [NCH];
  logic                         cv_hi_done [NCH];
  logic [NCH-1:0]               ch_flag;
  logic [NCH-1:0]               in_prev;
  logic [NCH-1:0]               level;
  captf_pkg::captf_mode_t       mode     [NCH];

  // bus decode signals
  logic                         wr_take;
  logic                         rd_take;
  logic [2:0]                   w_unit;
  logic [7:0]                   w_ofs;
  logic [2:0]                   r_unit;
  logic [7:0]                   r_ofs;
  logic                         w_lane0;
  logic [7:0]                   wbyte;
  logic                         sc_wr;
  logic                         cnt_wr;
  logic                         modl_wr;
  logic                         modh_wr;
  logic [NCH-1:0]               csc_wr;
  logic [NCH-1:0]               cvl_wr;
  logic [NCH-1:0]               cvh_wr;
  logic                         sc_rd;
  logic [NCH-1:0]               csc_rd;
  logic [31:0]                  next_rdata;
  logic                         next_rerr;

  // counter events
  logic [15:0]                  terminal;
  logic                         tick;
  logic                         ovf_evt;
  logic                         mod_load;
  logic [NCH-1:0]               match;
  logic [NCH-1:0]               ch_evt;

  // both address and data are taken together; no outstanding write
  assign wr_take       = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign s_axi_awready = wr_take;
  assign s_axi_wready  = wr_take;
  assign rd_take       = s_axi_arvalid && !s_axi_rvalid;
  assign s_axi_arready = !s_axi_rvalid;

  assign w_unit  = dec_unit(s_axi_awaddr);
  assign w_ofs   = dec_ofs(s_axi_awaddr);
  assign r_unit  = dec_unit(s_axi_araddr);
  assign r_ofs   = dec_ofs(s_axi_araddr);
  // registers are bytes, so only lane 0 carries a write
  assign w_lane0 = wr_take && s_axi_wstrb[0];
  assign wbyte   = s_axi_wdata[7:0];

  // timer register strobes
  assign sc_wr   = w_lane0 && w_unit == 3'd0 && w_ofs == captf_pkg::ADDR_SC;
  assign cnt_wr  = w_lane0 && w_unit == 3'd0 && w_ofs == captf_pkg::ADDR_CNT;
  assign modl_wr = w_lane0 && w_unit == 3'd0 && w_ofs == captf_pkg::ADDR_MODL;
  assign modh_wr = w_lane0 && w_unit == 3'd0 && w_ofs == captf_pkg::ADDR_MODH;
  assign sc_rd   = rd_take && r_unit == 3'd0 && r_ofs == captf_pkg::ADDR_SC;

  // channel register strobes
  always_comb begin
    for (int n = 0; n < NCH; n++) begin
      csc_wr[n] = w_lane0 && w_unit == 3'(n + 1) && w_ofs == captf_pkg::CH_OFS_SC;
      cvl_wr[n] = w_lane0 && w_unit == 3'(n + 1) && w_ofs == captf_pkg::CH_OFS_VL;
      cvh_wr[n] = w_lane0 && w_unit == 3'(n + 1) && w_ofs == captf_pkg::CH_OFS_VH;
      csc_rd[n] = rd_take && r_unit == 3'(n + 1) && r_ofs == captf_pkg::CH_OFS_SC;
      mode[n]   = ch_mode(chctl[n], center_align_select);
    end
  end

  // timer control fields
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ovf_ie <= 1'b0;
      center_align_select  <= 1'b0;
      run    <= 1'b0;
    end else if (sc_wr) begin
      ovf_ie <= wbyte[captf_pkg::SC_IE];
      center_align_select  <= wbyte[captf_pkg::SC_CENTER_ALIGN_SELECT];
      run    <= wbyte[captf_pkg::SC_RUN];
    end
  end

  // free-running terminal is all ones when the modulus is zero
  assign terminal = (mod_work == 16'h0000) ? captf_pkg::CNT_MAX : mod_work;
  assign tick     = run && !cnt_wr;
  // up/down: flag at the reversal from the modulus; up: flag at wrap
  assign ovf_evt  = tick && (center_align_select ? (!dir_down && cnt == mod_work)
                                   : (cnt == terminal));

  // main counter; both turning points are held for exactly one tick
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt      <= captf_pkg::CNT_RST;
      dir_down <= 1'b0;
    end else if (cnt_wr) begin
      cnt      <= captf_pkg::CNT_RST;
      dir_down <= 1'b0;
    end else if (!center_align_select) begin
      dir_down <= 1'b0;
      if (run)
        cnt <= (cnt == terminal) ? 16'h0000 : cnt + 16'h0001;
    end else if (run) begin
      if (!dir_down && cnt == mod_work) begin
        cnt      <= cnt - 16'h0001;
        dir_down <= 1'b1;
      end else if (dir_down && cnt == 16'h0000) begin
        cnt      <= 16'h0001;
        dir_down <= 1'b0;
      end else begin
        cnt <= dir_down ? cnt - 16'h0001 : cnt + 16'h0001;
      end
    end
  end

  // modulus loads at the period end, or at once while the counter is stopped
  assign mod_load = mod_lo_done && mod_hi_done && (ovf_evt || !run);

  // modulus holding buffer and byte pairing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mod_buf     <= captf_pkg::MOD_RST;
      mod_work    <= captf_pkg::MOD_RST;
      mod_lo_done <= 1'b0;
      mod_hi_done <= 1'b0;
    end else if (sc_wr) begin
      mod_lo_done <= 1'b0;
      mod_hi_done <= 1'b0;
    end else begin
      // load first so a byte landing in the load cycle opens the next pair
      if (mod_load) begin
        mod_work    <= mod_buf;
        mod_lo_done <= 1'b0;
        mod_hi_done <= 1'b0;
      end
      if (modl_wr) begin
        mod_buf[7:0] <= wbyte;
        mod_lo_done  <= 1'b1;
      end
      if (modh_wr) begin
        mod_buf[15:8] <= wbyte;
        mod_hi_done   <= 1'b1;
      end
    end
  end

  // channel compare and capture events
  always_comb begin
    for (int n = 0; n < NCH; n++) begin
      match[n] = tick && cnt == cv_work[n];
      unique case (mode[n])
        captf_pkg::MODE_IC:
          ch_evt[n] = run && unique0_edge(chctl[n], chan_in[n], in_prev[n]);
        captf_pkg::MODE_OC,
        captf_pkg::MODE_EPWM,
        captf_pkg::MODE_CPWM:
          ch_evt[n] = match[n];
        default:
          ch_evt[n] = 1'b0;
      endcase
    end
  end

  // selected input edge: 01 rising, 10 falling, 11 either, 00 none
  function automatic logic unique0_edge(input captf_pkg::captf_chctl_t c,
                                        input logic now, input logic prev);
    unique0_edge = (c.els_low && now && !prev) || (c.els_high && !now && prev);
  endfunction : unique0_edge

  // channel control and input history
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int n = 0; n < NCH; n++)
        chctl[n] <= captf_pkg::CHCTL_RST;
      in_prev <= '0;
    end else begin
      in_prev <= chan_in;
      for (int n = 0; n < NCH; n++) begin
        if (csc_wr[n])
          chctl[n] <= wbyte[captf_pkg::CSC_IE:captf_pkg::CSC_ELSA];
      end
    end
  end

  // channel value buffers: compare loads at once, pwm waits for its period boundary
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int n = 0; n < NCH; n++) begin
        cv_buf[n]     <= captf_pkg::CV_RST;
        cv_work[n]    <= captf_pkg::CV_RST;
        cv_lo_done[n] <= 1'b0;
        cv_hi_done[n] <= 1'b0;
      end
    end else begin
      for (int n = 0; n < NCH; n++) begin
        if (csc_wr[n]) begin
          cv_lo_done[n] <= 1'b0;
          cv_hi_done[n] <= 1'b0;
        end else begin
          if (cv_lo_done[n] && cv_hi_done[n] &&
              (!run || mode[n] == captf_pkg::MODE_OC ||
               (mode[n] == captf_pkg::MODE_EPWM && tick && cnt == 16'h0000) ||
               (mode[n] == captf_pkg::MODE_CPWM && ovf_evt))) begin
            cv_work[n]    <= cv_buf[n];
            cv_lo_done[n] <= 1'b0;
            cv_hi_done[n] <= 1'b0;
          end
          if (cvl_wr[n]) begin
            cv_buf[n][7:0] <= wbyte;
            cv_lo_done[n]  <= 1'b1;
          end
          if (cvh_wr[n]) begin
            cv_buf[n][15:8] <= wbyte;
            cv_hi_done[n]   <= 1'b1;
          end
        end
        // capture overrides any pending load
        if (mode[n] == captf_pkg::MODE_IC && ch_evt[n])
          cv_work[n] <= cnt;
      end
    end
  end

  // channel pin levels; pwm active level is high when the low polarity bit is clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      level <= '0;
    end else begin
      for (int n = 0; n < NCH; n++) begin
        unique case (mode[n])
          captf_pkg::MODE_OC: begin
            if (match[n])
              level[n] <= chctl[n].els_low & (chctl[n].els_high | ~level[n]);
          end
          captf_pkg::MODE_EPWM: begin
            // match wins over overflow so a zero value gives zero duty
            if (match[n])
              level[n] <= chctl[n].els_low;
            else if (tick && cnt == 16'h0000)
              level[n] <= ~chctl[n].els_low;
          end
          captf_pkg::MODE_CPWM: begin
            if (cv_work[n] == 16'h0000 || cv_work[n][15])
              level[n] <= chctl[n].els_low;
            else if (cv_work[n] > mod_work && mod_work != 16'h0000)
              level[n] <= ~chctl[n].els_low;
            else if (match[n])
              level[n] <= dir_down ^ chctl[n].els_low;
          end
          default: begin
            level[n] <= level[n];
          end
        endcase
      end
    end
  end

  assign chan_out = level;

  // pins are driven only in output modes with a nonzero level select
  always_comb begin
    for (int n = 0; n < NCH; n++)
      chan_oe[n] = mode[n] != captf_pkg::MODE_IC && mode[n] != captf_pkg::MODE_OFF &&
                   (chctl[n].els_high || chctl[n].els_low);
  end

  // overflow flag and per-channel flags share the two-step clear
  captf_flag u_ovf_flag (
    .aclk    (aclk),
    .aresetn (aresetn),
    .set_evt (ovf_evt),
    .rd_seen (sc_rd),
    .wr_zero (sc_wr && !wbyte[captf_pkg::SC_FLAG]),
    .flag    (ovf_flag)
  );

  for (genvar g = 0; g < NCH; g++) begin : g_chflag
    captf_flag u_ch_flag (
      .aclk    (aclk),
      .aresetn (aresetn),
      .set_evt (ch_evt[g]),
      .rd_seen (csc_rd[g]),
      .wr_zero (csc_wr[g] && !wbyte[captf_pkg::CSC_FLAG]),
      .flag    (ch_flag[g])
    );
  end

  // static interrupt levels
  assign overflow_irq = ovf_flag && ovf_ie;
  always_comb begin
    for (int n = 0; n < NCH; n++)
      channel_irq[n] = ch_flag[n] && chctl[n].ie;
  end

  // read multiplexer
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_rerr  = 1'b0;
    if (r_unit == 3'd0) begin
      unique case (r_ofs)
        captf_pkg::ADDR_SC:
          next_rdata[7:0] = {ovf_flag, ovf_ie, center_align_select, 1'b0, run, 3'b000};
        captf_pkg::ADDR_CNT:  next_rdata[15:0] = cnt;
        captf_pkg::ADDR_MODL: next_rdata[7:0]  = mod_work[7:0];
        captf_pkg::ADDR_MODH: next_rdata[7:0]  = mod_work[15:8];
        default:              next_rerr = 1'b1;
      endcase
    end else if (r_unit <= 3'(NCH)) begin
      for (int n = 0; n < NCH; n++) begin
        if (r_unit == 3'(n + 1)) begin
          unique case (r_ofs)
            captf_pkg::CH_OFS_SC: next_rdata[7:0] = {ch_flag[n], chctl[n], 2'b00};
            captf_pkg::CH_OFS_VL: next_rdata[7:0] = cv_work[n][7:0];
            captf_pkg::CH_OFS_VH: next_rdata[7:0] = cv_work[n][15:8];
            default:              next_rerr = 1'b1;
          endcase
        end
      end
    end else begin
      next_rerr = 1'b1;
    end
  end

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= captf_pkg::RESP_OKAY;
    end else if (wr_take) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (w_unit > 3'(NCH)) ? captf_pkg::RESP_SLVERR : captf_pkg::RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= captf_pkg::RESP_OKAY;
    end else if (rd_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= next_rerr ? captf_pkg::RESP_SLVERR : captf_pkg::RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : captf_timer

`default_nettype wire

// File: test/captf_timer_properties.sv
// checker: bus handshake and interrupt-line properties of the pwm timer
`timescale 1ns/1ps
`default_nettype none

module captf_timer_properties (
  input wire logic                      aclk,
  input wire logic                      aresetn,
  input wire logic                      s_axi_awvalid,
  input wire logic                      s_axi_awready,
  input wire logic [1:0]                s_axi_bresp,
  input wire logic                      s_axi_bvalid,
  input wire logic                      s_axi_bready,
  input wire logic                      s_axi_arvalid,
  input wire logic                      s_axi_arready,
  input wire logic [31:0]               s_axi_rdata,
  input wire logic                      s_axi_rvalid,
  input wire logic                      s_axi_rready,
  input wire logic [captf_pkg::NCH-1:0] chan_oe,
  input wire logic                      overflow_irq,
  input wire logic [captf_pkg::NCH-1:0] channel_irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // a register write lands at this edge; flags and controls may only drop after one
  wire aw_hs = s_axi_awvalid && s_axi_awready;

  property p_wr_resp; aw_hs |=> s_axi_bvalid && s_axi_bresp == 2'h0 || s_axi_bvalid; endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write answer late");
  property p_rd_resp; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rd_resp: assert property (p_rd_resp) else $error("read answer late");
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  property p_aw_block; s_axi_bvalid |-> !s_axi_awready; endproperty
  a_aw_block: assert property (p_aw_block) else $error("write taken over answer");
  // an interrupt level can only fall through a register write
  property p_ovf_fall; $fell(overflow_irq) |-> $past(aw_hs); endproperty
  a_ovf_fall: assert property (p_ovf_fall) else $error("overflow irq fell alone");
  property p_ch_fall; |($past(channel_irq) & ~channel_irq) |-> $past(aw_hs); endproperty
  a_ch_fall: assert property (p_ch_fall) else $error("channel irq fell alone");
  property p_oe_chg; $changed(chan_oe) |-> $past(aw_hs); endproperty
  a_oe_chg: assert property (p_oe_chg) else $error("pin enable moved alone");
endmodule : captf_timer_properties

bind captf_timer captf_timer_properties u_props (.*);

`default_nettype wire

// File: test/tb_top.sv
// testbench: register-driven checks of center-aligned pwm duty, reloads and flags
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin err_count++; \
  $display("unexpected %s exp %0h got %0h", n, e, s); end end

module tb_top;
  logic                      aclk = 1'b0;
  logic                      aresetn = 1'b0;
  logic [7:0]                s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0]               s_axi_wdata = 32'h0, s_axi_rdata, rv;
  logic [1:0]                s_axi_bresp, s_axi_rresp, rr, br;
  logic                      s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic                      s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic                      s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic                      s_axi_arready, s_axi_rvalid, overflow_irq, seen;
  logic [captf_pkg::NCH-1:0] chan_in = '0, chan_out, chan_oe, channel_irq;
  logic [31:0]               seed = 32'h3E54DB12;
  logic [15:0]               md, v;
  int                        err_count = 0, cmp_count = 0, n, k;
  wire  [3:0]                s_axi_wstrb = 4'hF;

  captf_timer dut (.*);

  always #50 aclk = ~aclk;
  // input pins wander so the capture logic sees edges
  always @(posedge aclk) chan_in <= chan_in + 2'h1;

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs

  // high cycles per period of 2*m clocks for value c
  function automatic int exp_hi(input logic [15:0] m, input logic [15:0] c, input logic inv);
    int h;
    if (c == 16'h0 || c[15]) h = 0;
    else if (c > m) h = 2 * m;
    else h = 2 * c;
    return inv ? 2 * m - h : h;
  endfunction : exp_hi

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish

  // one clock of waiting; a stuck handshake ends the run
  task automatic step(inout int t);
    @(posedge aclk);
    t++;
    if (t > 50) begin
      err_count++;
      tally_and_finish();
    end
  endtask : step

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int t;
    @(posedge aclk);
    t = 0;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      step(t);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while ((s_axi_awvalid && !s_axi_awready) !== 1'b0 ||
               (s_axi_wvalid && !s_axi_wready) !== 1'b0);
    do step(t); while (s_axi_bvalid !== 1'b1);
    br = s_axi_bresp;
    s_axi_bready  <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    int t;
    @(posedge aclk);
    t = 0;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do step(t); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do step(t); while (s_axi_rvalid !== 1'b1);
    rv = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready  <= 1'b0;
  endtask : rd

  // settle three periods so reloads land, then count high cycles over one period
  task automatic meas;
    repeat (6 * md) @(posedge aclk);
    n = 0;
    seen = 1'b0;
    repeat (2 * md) begin
      @(posedge aclk);
      n += (chan_out[0] === 1'b1) + 999 * $isunknown(chan_out[0]);
      seen |= channel_irq[0];
    end
  endtask : meas

  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h40);
    `CHK("unmapped resp", captf_pkg::RESP_SLVERR, rr)
    wr(8'h40, 8'hFF);
    `CHK("unmapped wresp", captf_pkg::RESP_SLVERR, br)
    seed = xs(seed);
    md = 16'h6 + seed[3:0];
    wr(captf_pkg::ADDR_MODL, md[7:0]);
    wr(captf_pkg::ADDR_MODH, md[15:8]);
    `CHK("write resp", captf_pkg::RESP_OKAY, br)
    // lone low byte, then a control write must drop it
    wr(captf_pkg::ADDR_MODL, 8'hFF);
    wr(captf_pkg::ADDR_SC, 8'h00);
    wr(captf_pkg::ADDR_MODH, 8'h00);
    rd(captf_pkg::ADDR_MODL);
    `CHK("modulus low", md[7:0], rv[7:0])
    wr(captf_pkg::ADDR_SC, 8'h68);
    for (k = 0; k < 5; k++) begin
      seed = xs(seed);
      v = 16'h1 + seed[15:0] % (md - 16'h1);
      if (k == 2) v = 16'h0;
      if (k == 3) v = 16'h8000;
      if (k == 4) v = md + 16'h1;
      wr(captf_pkg::CH_BASE, (k == 1) ? 8'h44 : 8'h48);
      wr(captf_pkg::CH_BASE + captf_pkg::CH_OFS_VL, v[7:0]);
      wr(captf_pkg::CH_BASE + captf_pkg::CH_OFS_VH, v[15:8]);
      meas();
      `CHK("high cycles", exp_hi(md, v, k == 1), n)
      `CHK("pin enable", 1'b1, chan_oe[0])
      if (k == 0) `CHK("channel irq", 1'b1, seen)
    end
    // half-written values stay pending, and a control write drops them
    wr(captf_pkg::CH_BASE + captf_pkg::CH_OFS_VL, 8'h00);
    wr(captf_pkg::CH_BASE, 8'h48);
    wr(captf_pkg::CH_BASE + captf_pkg::CH_OFS_VH, 8'h00);
    meas();
    `CHK("held duty", 2 * md, n)
    wr(captf_pkg::ADDR_SC, 8'h60);
    `CHK("overflow irq kept", 1'b1, overflow_irq)
    rd(captf_pkg::ADDR_SC);
    `CHK("overflow flag", 1'b1, rv[7])
    wr(captf_pkg::ADDR_SC, 8'h60);
    `CHK("overflow irq clear", 1'b0, overflow_irq)
    // up mode wraps at the modulus; channel 1 captures rising edges
    wr(captf_pkg::ADDR_SC, 8'h08);
    wr(captf_pkg::CH_BASE + captf_pkg::CH_STRIDE, 8'h04);
    repeat (2 * md) @(posedge aclk);
    rd(captf_pkg::ADDR_SC);
    `CHK("wrap flag", 1'b1, rv[7])
    rd(captf_pkg::CH_BASE + captf_pkg::CH_STRIDE);
    `CHK("capture flag", 1'b1, rv[7])
    tally_and_finish();
  end
endmodule : tb_top

`default_nettype wire
